// *** src/jlc_pkg.sv ***
// jlc_pkg: constants, types and register map for the link configuration checker
// assumes: 32-bit axi4-lite slave, rates given in mhz units (mbps and msps)
package jlc_pkg;

  localparam logic [15:0] ADDR_CFG    = 16'h0000;
  localparam logic [15:0] ADDR_RATE   = 16'h0004;
  localparam logic [15:0] ADDR_STATUS = 16'h0008;
  localparam logic [15:0] ADDR_LRATE  = 16'h000c;
  // pll range register index, byte address is four times it
  localparam logic [15:0] IDX_PLL     = 16'h056e;
  localparam logic [15:0] ADDR_PLL    = IDX_PLL << 2;
  localparam logic [15:0] ADDR_MASK   = 16'hfffc;

  // rates in tenths of mbps: 1687.5 mbps kept as 16875 tenths
  localparam int unsigned SLR_MIN_X10   = 16875;
  localparam int unsigned SLR_MAX_X10   = 155000;
  localparam int unsigned BAND1_X10     = 33750;
  localparam int unsigned BAND2_X10     = 67500;
  localparam int unsigned BAND3_X10     = 135000;
  localparam int unsigned TBL_B1_X10    = 34000;
  localparam int unsigned TBL_B2_X10    = 68000;
  localparam int unsigned SLR_CLK_DIV   = 40;
  localparam int unsigned LCM_DIV_K     = 20;
  localparam int unsigned LCM_MAX       = 64;
  localparam int unsigned KF_DIV        = 4;
  localparam int unsigned K_MAX         = 32;
  localparam int unsigned WORD_MULT     = 10;

  localparam logic [7:0] PLL_BAND4 = 8'h30;
  localparam logic [7:0] PLL_BAND3 = 8'h00;
  localparam logic [7:0] PLL_BAND2 = 8'h10;
  localparam logic [7:0] PLL_BAND1 = 8'h50;
  localparam logic [7:0] PLL_RESET = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // config word fields
  typedef struct packed {
    logic [3:0] cs;
    logic [3:0] n;
    logic       hd;
    logic [5:0] k;
    logic [4:0] f;
    logic [2:0] m;
    logic [2:0] l;
    logic [5:0] chip_decimation_ratio;
  } jlc_cfg_s;

  typedef struct packed {
    logic [19:0] slr_x10;
    logic [7:0]  pll_hint;
    logic [4:0]  s;
    logic        ok;
    logic [9:0]  err;
  } jlc_res_s;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CALC = 4'b0010,
    ST_LCM  = 4'b0100,
    ST_DONE = 4'b1000
  } jlc_state_e;

endpackage

// *** src/jlc_checker.sv ***
// jlc_checker: axi4-lite register file plus sequential link setting checker
// assumes: software writes cfg and converter rate, then writes the rate register to start
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
module jlc_checker (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write address and data
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // read
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // checked result stream
  output logic             res_valid,
  input  wire logic        res_ready,
  output jlc_pkg::jlc_res_s res_data,
  // pll range value in force
  output logic [7:0]       lane_pll_range
);

  ////////////////////////////////////////////////////////////////////////////
  // band index 0..3 for table columns and pll ranges
  function automatic logic [1:0] band_of(input logic [19:0] r, input logic [19:0] b1,
                                         input logic [19:0] b2);
    if (r < b1) return 2'd0;
    else if (r < b2) return 2'd1;
    else if (r <= 20'(jlc_pkg::BAND3_X10)) return 2'd2;
    else return 2'd3;
  endfunction

  // highest listed decimation per row and band, as a bit mask of allowed ratios
  function automatic logic [31:0] dcm_mask(input logic [2:0] l, input logic [2:0] m,
                                           input logic [1:0] bnd);
    logic [31:0] full;
    full = 32'h0000_0000;
    if (m == 3'd1 && l == 3'd1) begin
      case (bnd)
        2'd0: full = 32'h0000_157e;
        2'd1: full = 32'h0000_017e;
        2'd2: full = 32'h0000_001e;
        default: full = 32'h0000_0006;
      endcase
    end else if ((m == 3'd1 && l == 3'd2) || (m == 3'd2 && l == 3'd4)) begin
      case (bnd)
        2'd0: full = 32'h0000_017e;
        2'd1: full = 32'h0000_001e;
        2'd2: full = 32'h0000_0006;
        default: full = 32'h0000_0002;
      endcase
    end else if (m == 3'd1 && l == 3'd4) begin
      case (bnd)
        2'd0: full = 32'h0000_001e;
        2'd1: full = 32'h0000_0006;
        2'd2: full = 32'h0000_0002;
        default: full = 32'h0000_0000;
      endcase
    end else if (m == 3'd2 && l == 3'd1) begin
      case (bnd)
        2'd0: full = 32'h4111_9574;
        2'd1: full = 32'h0001_957e;
        2'd2: full = 32'h0000_017e;
        default: full = 32'h0000_001e;
      endcase
    end else if (m == 3'd2 && l == 3'd2) begin
      case (bnd)
        2'd0: full = 32'h0001_957e;
        2'd1: full = 32'h0000_017e;
        2'd2: full = 32'h0000_001e;
        default: full = 32'h0000_0006;
      endcase
    end
    return full;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers
  jlc_pkg::jlc_cfg_s  cfg_r, cfg_nxt;
  logic [15:0]        fadc_r, fadc_nxt;
  logic [7:0]         pll_r, pll_nxt;
  jlc_pkg::jlc_state_e st_r, st_nxt;
  logic [19:0]        slr_r, slr_nxt;
  logic [19:0]        fout_r, fout_nxt;
  logic [9:0]         err_r, err_nxt;
  logic [5:0]         ratio_r, ratio_nxt;
  logic               busy_r, busy_nxt;
  jlc_pkg::jlc_res_s  res_r, res_nxt;
  logic               start_r, start_nxt;

  // bus state
  logic aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt;
  logic [15:0] awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt;
  logic [3:0]  ws_r, ws_nxt;
  logic bv_r, bv_nxt, rv_r, rv_nxt;
  logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
  logic [31:0] rd_r, rd_nxt;

  // two-entry result buffer
  jlc_pkg::jlc_res_s buf_r [2];
  jlc_pkg::jlc_res_s buf_nxt [2];
  logic [1:0] cnt_r, cnt_nxt;
  logic       push;
  logic       pop;
  assign push = (st_r == jlc_pkg::ST_DONE) && (cnt_r != 2'd2);
  assign pop  = res_valid && res_ready;

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  always_comb begin
    aw_ok_nxt = aw_ok_r;
    w_ok_nxt  = w_ok_r;
    awa_nxt   = awa_r;
    wd_nxt    = wd_r;
    ws_nxt    = ws_r;
    bv_nxt    = bv_r;
    br_nxt    = br_r;
    rv_nxt    = rv_r;
    rr_nxt    = rr_r;
    rd_nxt    = rd_r;
    cfg_nxt   = cfg_r;
    fadc_nxt  = fadc_r;
    pll_nxt   = pll_r;
    start_nxt = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_ok_nxt = 1'b1;
      awa_nxt   = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_ok_nxt = 1'b1;
      wd_nxt   = s_axi_wdata;
      ws_nxt   = s_axi_wstrb;
    end
    if (aw_ok_r && w_ok_r && !bv_r) begin
      aw_ok_nxt = 1'b0;
      w_ok_nxt  = 1'b0;
      bv_nxt    = 1'b1;
      br_nxt    = jlc_pkg::RESP_OKAY;
      case (awa_r & jlc_pkg::ADDR_MASK)
        jlc_pkg::ADDR_CFG: begin
          if (ws_r == 4'hf) cfg_nxt = jlc_pkg::jlc_cfg_s'(wd_r[31:0]);
        end
        jlc_pkg::ADDR_RATE: begin
          // rate held while a check runs
          if (ws_r[0] && !busy_r) fadc_nxt[7:0] = wd_r[7:0];
          if (ws_r[1] && !busy_r) fadc_nxt[15:8] = wd_r[15:8];
          start_nxt = !busy_r;
        end
        jlc_pkg::ADDR_PLL: begin
          if (ws_r[0]) pll_nxt = wd_r[7:0];
        end
        default: br_nxt = jlc_pkg::RESP_SLVERR;
      endcase
    end
    if (bv_r && s_axi_bready) bv_nxt = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      rv_nxt = 1'b1;
      rr_nxt = jlc_pkg::RESP_OKAY;
      case (s_axi_araddr & jlc_pkg::ADDR_MASK)
        jlc_pkg::ADDR_CFG:    rd_nxt = 32'(cfg_r);
        jlc_pkg::ADDR_RATE:   rd_nxt = {16'h0000, fadc_r};
        jlc_pkg::ADDR_STATUS: rd_nxt = {20'h00000, busy_r, res_r.ok, err_r};
        jlc_pkg::ADDR_LRATE:  rd_nxt = {4'h0, res_r.pll_hint, slr_r};
        jlc_pkg::ADDR_PLL:    rd_nxt = {24'h000000, pll_r};
        default: begin
          rd_nxt = 32'h0000_0000;
          rr_nxt = jlc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rv_r && s_axi_rready) begin
      rv_nxt = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checker sequence
  always_comb begin
    logic [31:0] slr_wide;
    logic [31:0] msk;
    logic [11:0] lcm;
    logic [9:0]  kf;
    logic [4:0]  kmin;
    slr_wide  = 32'h0000_0000;
    msk       = 32'h0000_0000;
    lcm       = 12'h000;
    kf        = 10'(cfg_r.k) * 10'(cfg_r.f);
    kmin      = 5'd4;
    st_nxt    = st_r;
    slr_nxt   = slr_r;
    fout_nxt  = fout_r;
    err_nxt   = err_r;
    ratio_nxt = ratio_r;
    busy_nxt  = busy_r;
    res_nxt   = res_r;
    case (st_r)
      jlc_pkg::ST_IDLE: begin
        if (start_r) begin
          busy_nxt = 1'b1;
          err_nxt  = 10'h000;
          fout_nxt = (cfg_r.chip_decimation_ratio == 6'h00) ? 20'h00000 : 20'(fadc_r / cfg_r.chip_decimation_ratio);
          st_nxt   = jlc_pkg::ST_CALC;
        end
      end
      jlc_pkg::ST_CALC: begin
        // lane rate in tenths of mbps
        if (cfg_r.l != 3'd0)
          slr_wide = (32'(fout_r) * 32'(jlc_pkg::WORD_MULT * jlc_pkg::WORD_MULT)
                      * 32'(cfg_r.m)) / 32'(cfg_r.l);
        // saturate so that a huge rate cannot wrap into the legal range
        slr_nxt = (slr_wide > 32'h000f_ffff) ? 20'hfffff : slr_wide[19:0];
        ratio_nxt = (cfg_r.m == 3'd2) ? 6'(cfg_r.l) : 6'(2 * cfg_r.l);
        if (!(cfg_r.l == 3'd1 || cfg_r.l == 3'd2 || cfg_r.l == 3'd4) ||
            !(cfg_r.m == 3'd1 || cfg_r.m == 3'd2) || cfg_r.hd ||
            cfg_r.n < 4'd7 || cfg_r.n > 4'd8 || cfg_r.cs > 4'd1 || cfg_r.chip_decimation_ratio == 6'h00)
          err_nxt[0] = 1'b1;
        if ((kf % 10'(jlc_pkg::KF_DIV)) != 10'h000) err_nxt[1] = 1'b1;
        case (cfg_r.f)
          5'd1:  kmin = 5'd20;
          5'd2:  kmin = 5'd12;
          5'd4:  kmin = 5'd8;
          5'd8, 5'd16: kmin = 5'd4;
          default: err_nxt[2] = 1'b1;
        endcase
        if (cfg_r.k[1:0] != 2'b00 || cfg_r.k < 6'(kmin) ||
            cfg_r.k > 6'(jlc_pkg::K_MAX)) err_nxt[2] = 1'b1;
        if (6'(cfg_r.f) * 6'(cfg_r.l) < 6'(cfg_r.m)) err_nxt[3] = 1'b1;
        st_nxt = jlc_pkg::ST_LCM;
      end
      jlc_pkg::ST_LCM: begin
        if (slr_r < 20'(jlc_pkg::SLR_MIN_X10) || slr_r > 20'(jlc_pkg::SLR_MAX_X10))
          err_nxt[4] = 1'b1;
        // lane rate over 40 against converter rate, slr kept in tenths
        if (32'(slr_r) > 32'(fadc_r) * 32'(jlc_pkg::SLR_CLK_DIV * jlc_pkg::WORD_MULT))
          err_nxt[5] = 1'b1;
        // first term is 2 x l x dcm / m, a multiple of dcm, so it is the lcm
        lcm = 12'(ratio_r) * 12'(cfg_r.chip_decimation_ratio);
        if (lcm > 12'(jlc_pkg::LCM_MAX)) err_nxt[6] = 1'b1;
        msk = dcm_mask(cfg_r.l, cfg_r.m, band_of(slr_r, 20'(jlc_pkg::TBL_B1_X10),
                                                 20'(jlc_pkg::TBL_B2_X10)));
        if (cfg_r.chip_decimation_ratio > 6'd31 || !msk[cfg_r.chip_decimation_ratio[4:0]]) err_nxt[7] = 1'b1;
        res_nxt.slr_x10 = slr_r;
        case (band_of(slr_r, 20'(jlc_pkg::BAND1_X10), 20'(jlc_pkg::BAND2_X10)))
          2'd0: res_nxt.pll_hint = jlc_pkg::PLL_BAND1;
          2'd1: res_nxt.pll_hint = jlc_pkg::PLL_BAND2;
          2'd2: res_nxt.pll_hint = jlc_pkg::PLL_BAND3;
          default: res_nxt.pll_hint = jlc_pkg::PLL_BAND4;
        endcase
        res_nxt.s = (cfg_r.m == 3'd0) ? 5'h00 :
                    5'((10'(cfg_r.f) * 10'(cfg_r.l)) / 10'(cfg_r.m));
        st_nxt = jlc_pkg::ST_DONE;
      end
      jlc_pkg::ST_DONE: begin
        res_nxt.err = err_r;
        res_nxt.ok  = (err_r == 10'h000);
        if (cnt_r != 2'd2) begin
          busy_nxt = 1'b0;
          st_nxt   = jlc_pkg::ST_IDLE;
        end
      end
      default: st_nxt = jlc_pkg::ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // result buffer
  jlc_pkg::jlc_res_s push_word;
  always_comb begin
    push_word     = res_r;
    push_word.err = err_r;
    push_word.ok  = (err_r == 10'h000);
    buf_nxt[0] = buf_r[0];
    buf_nxt[1] = buf_r[1];
    cnt_nxt    = cnt_r;
    if (pop) begin
      buf_nxt[0] = buf_r[1];
      cnt_nxt    = cnt_r - 2'd1;
    end
    if (push) begin
      buf_nxt[(pop ? cnt_r - 2'd1 : cnt_r) == 2'd0 ? 0 : 1] = push_word;
      cnt_nxt = pop ? cnt_r : cnt_r + 2'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_r <= 1'b0;
      w_ok_r  <= 1'b0;
      awa_r   <= 16'h0000;
      wd_r    <= 32'h0000_0000;
      ws_r    <= 4'h0;
      bv_r    <= 1'b0;
      br_r    <= 2'b00;
      rv_r    <= 1'b0;
      rr_r    <= 2'b00;
      rd_r    <= 32'h0000_0000;
      cfg_r   <= '0;
      fadc_r  <= 16'h0000;
      pll_r   <= jlc_pkg::PLL_RESET;
      start_r <= 1'b0;
      st_r    <= jlc_pkg::ST_IDLE;
      slr_r   <= 20'h00000;
      fout_r  <= 20'h00000;
      err_r   <= 10'h000;
      ratio_r <= 6'h00;
      busy_r  <= 1'b0;
      res_r   <= '0;
      buf_r[0] <= '0;
      buf_r[1] <= '0;
      cnt_r   <= 2'd0;
    end else begin
      aw_ok_r <= aw_ok_nxt;
      w_ok_r  <= w_ok_nxt;
      awa_r   <= awa_nxt;
      wd_r    <= wd_nxt;
      ws_r    <= ws_nxt;
      bv_r    <= bv_nxt;
      br_r    <= br_nxt;
      rv_r    <= rv_nxt;
      rr_r    <= rr_nxt;
      rd_r    <= rd_nxt;
      cfg_r   <= cfg_nxt;
      fadc_r  <= fadc_nxt;
      pll_r   <= pll_nxt;
      start_r <= start_nxt;
      st_r    <= st_nxt;
      slr_r   <= slr_nxt;
      fout_r  <= fout_nxt;
      err_r   <= err_nxt;
      ratio_r <= ratio_nxt;
      busy_r  <= busy_nxt;
      res_r   <= res_nxt;
      buf_r[0] <= buf_nxt[0];
      buf_r[1] <= buf_nxt[1];
      cnt_r   <= cnt_nxt;
    end
  end

  // outputs from flip-flops
  assign s_axi_awready  = !aw_ok_r;
  assign s_axi_wready   = !w_ok_r;
  assign s_axi_bvalid   = bv_r;
  assign s_axi_bresp    = br_r;
  assign s_axi_arready  = !rv_r;
  assign s_axi_rvalid   = rv_r;
  assign s_axi_rdata    = rd_r;
  assign s_axi_rresp    = rr_r;
  assign res_valid      = (cnt_r != 2'd0);
  assign res_data       = buf_r[0];
  assign lane_pll_range = pll_r;

endmodule

// *** tb/jlc_checker_assertions.sv ***
// jlc_checker_assertions: handshake and result checks on the checker ports
// assumes: bound to jlc_checker, one aclk domain, sync active-low reset
`timescale 1ns/100ps
module jlc_checker_assertions (
  // clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // axi handshakes
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  // result stream
  input wire logic              res_valid,
  input wire logic              res_ready,
  input wire jlc_pkg::jlc_res_s res_data
);
  logic [7:0] hint_exp;
  logic       res_ok;

  // band value worked out from the lane rate
  always_comb begin
    if (res_data.slr_x10 > jlc_pkg::BAND3_X10) hint_exp = 8'h30;
    else if (res_data.slr_x10 >= jlc_pkg::BAND2_X10) hint_exp = 8'h00;
    else if (res_data.slr_x10 >= jlc_pkg::BAND1_X10) hint_exp = 8'h10;
    else hint_exp = 8'h50;
  end
  assign res_ok = res_valid && res_data.ok;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_w_taken; s_axi_wvalid && s_axi_wready; endsequence
  sequence s_ar_taken; s_axi_arvalid && s_axi_arready; endsequence
  property p_aw_hold; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
  property p_wr_resp; s_w_taken |-> ##[1:6] s_axi_bvalid; endproperty
  property p_rd_resp; s_ar_taken |=> s_axi_rvalid; endproperty
  property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_res_hold; res_valid && !res_ready |=> res_valid && $stable(res_data); endproperty
  property p_ok_clean;
    res_ok |-> res_data.err == 10'h000 && res_data.slr_x10 >= jlc_pkg::SLR_MIN_X10
      && res_data.slr_x10 <= jlc_pkg::SLR_MAX_X10;
  endproperty
  property p_hint; res_ok |-> res_data.pll_hint == hint_exp; endproperty
  property p_s_val; res_ok |-> res_data.s inside {5'h01, 5'h02, 5'h04, 5'h08}; endproperty

  a_aw_hold: assert property (p_aw_hold) else $error("awready high after address taken");
  a_wr_resp: assert property (p_wr_resp) else $error("write response late");
  a_rd_resp: assert property (p_rd_resp) else $error("read data late");
  a_ar_block: assert property (p_ar_block) else $error("arready high during read answer");
  a_res_hold: assert property (p_res_hold) else $error("result changed while stalled");
  a_ok_clean: assert property (p_ok_clean) else $error("accepted result out of range");
  a_hint: assert property (p_hint) else $error("range hint wrong for lane rate");
  a_s_val: assert property (p_s_val) else $error("samples per frame not legal");
endmodule

bind jlc_checker jlc_checker_assertions u_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .res_valid, .res_ready, .res_data);

// *** tb/jlc_res_sink.sv ***
// jlc_res_sink: far-side receiver of checked results, stalls on request
// assumes: bench drives stall after a rising edge
`timescale 1ns/100ps
module jlc_res_sink (
  // clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // stall request from the bench
  input wire logic              stall,
  // result stream
  input wire logic              res_valid,
  output logic                  res_ready,
  input wire jlc_pkg::jlc_res_s res_data
);
  jlc_pkg::jlc_res_s got[$];

  always @(posedge aclk) begin
    if (!aresetn) begin
      res_ready <= 1'b0;
    end else begin
      res_ready <= !stall;
      if (res_valid && res_ready) got.push_back(res_data);
    end
  end
endmodule

// *** tb/jlc_checker_test.sv ***
// jlc_checker_test: register-level bench for the link setting checker
// assumes: package, design, sink and bound assertions compiled first
`timescale 1ns/100ps
module jlc_checker_test;
  logic              aclk = 1'b0, aresetn = 1'b0, stall = 1'b0;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [15:0]       s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
  logic [31:0]       s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]        s_axi_wstrb = 4'hf;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic              res_valid, res_ready;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [7:0]        lane_pll_range;
  jlc_pkg::jlc_res_s res_data;
  int                errors = 0, comparisons = 0;

  always #2.5 aclk = ~aclk;

  jlc_checker uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .res_valid, .res_ready, .res_data, .lane_pll_range);
  jlc_res_sink snk (.aclk, .aresetn, .stall, .res_valid, .res_ready, .res_data);

  ////////////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task hang;
    errors++;
    report_and_stop();
  endtask
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (i == 50) hang();
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (i == 50) hang();
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task get(output jlc_pkg::jlc_res_s r);
    int i;
    for (i = 0; i < 200; i++) begin
      @(posedge aclk);
      if (snk.got.size() > 0) break;
    end
    if (i == 200) hang();
    r = snk.got.pop_front();
  endtask
  function automatic jlc_pkg::jlc_cfg_s cfgw(input int l, m, f, k, chip_decimation_ratio, n);
    cfgw = '0;
    cfgw.l = 3'(l);
    cfgw.m = 3'(m);
    cfgw.f = 5'(f);
    cfgw.k = 6'(k);
    cfgw.chip_decimation_ratio = 6'(chip_decimation_ratio);
    cfgw.n = 4'(n);
  endfunction
  function automatic logic [7:0] hint(input int x);
    if (x > jlc_pkg::BAND3_X10) return 8'h30;
    if (x >= jlc_pkg::BAND2_X10) return 8'h00;
    if (x >= jlc_pkg::BAND1_X10) return 8'h10;
    return 8'h50;
  endfunction
  // one check run; eb < 0 expects acceptance, else the error bit eb
  task tc(input int l, m, f, k, chip_decimation_ratio, n, fadc, eb);
    jlc_pkg::jlc_res_s r;
    logic [1:0] rs;
    logic [31:0] d;
    int x;
    wr(jlc_pkg::ADDR_CFG, cfgw(l, m, f, k, chip_decimation_ratio, n), rs);
    wr(jlc_pkg::ADDR_RATE, 32'(fadc), rs);
    get(r);
    x = 100 * m * fadc / (chip_decimation_ratio * l);
    if (eb < 0) begin
      chk("ok", 32'(r.ok), 32'h1);
      chk("slr", 32'(r.slr_x10), 32'(x));
      chk("hint", 32'(r.pll_hint), 32'(hint(x)));
      chk("s", 32'(r.s), 32'(f * l / m));
      rd(jlc_pkg::ADDR_LRATE, d, rs);
      chk("lrate", d, {4'h0, hint(x), 20'(x)});
    end else begin
      chk("err bit", 32'(r.err[eb]), 32'h1);
      rd(jlc_pkg::ADDR_STATUS, d, rs);
      chk("status err", 32'(d[eb]), 32'h1);
      chk("status ok", 32'(d[10]), 32'h0);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    jlc_pkg::jlc_res_s r;
    logic [31:0] d;
    logic [1:0] rs;
    int fq[3];
    fq = '{1000, 1500, 500};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(jlc_pkg::ADDR_PLL, d, rs);
    chk("pll reset", d, 32'h0);
    wr(jlc_pkg::ADDR_PLL, 32'(jlc_pkg::PLL_BAND1), rs);
    chk("pll bresp", 32'(rs), 32'(jlc_pkg::RESP_OKAY));
    rd(jlc_pkg::ADDR_PLL, d, rs);
    chk("pll read", d, 32'h50);
    chk("pll pin", 32'(lane_pll_range), 32'h50);
    rd(16'h0100, d, rs);
    chk("unmapped", 32'(rs), 32'(jlc_pkg::RESP_SLVERR));
    wr(16'h0100, 32'h0, rs);
    chk("unmapped wr", 32'(rs), 32'(jlc_pkg::RESP_SLVERR));
    tc(1, 1, 1, 32, 1, 8, 1000, -1);
    tc(1, 1, 1, 32, 1, 8, 1500, -1);
    tc(1, 1, 1, 32, 1, 8, 1350, -1);
    tc(1, 1, 1, 32, 1, 8, 675, -1);
    tc(1, 1, 1, 32, 1, 8, 500, -1);
    tc(4, 1, 2, 32, 1, 8, 1350, -1);
    tc(4, 1, 2, 32, 1, 8, 675, -1);
    tc(1, 2, 2, 32, 2, 8, 200, -1);
    tc(1, 1, 1, 32, 1, 8, 100, 4);
    tc(1, 1, 1, 32, 1, 8, 1600, 4);
    tc(1, 1, 1, 16, 1, 8, 1000, 2);
    tc(1, 1, 1, 22, 1, 8, 1000, 1);
    tc(1, 1, 1, 32, 3, 8, 4500, 7);
    tc(4, 1, 1, 32, 12, 8, 9600, 6);
    tc(1, 1, 1, 32, 1, 9, 1000, 0);
    tc(1, 3, 1, 32, 1, 8, 1000, 0);
    tc(1, 2, 1, 32, 2, 8, 200, 3);
    // fill the two-entry buffer with the receiver stalled, then drain
    stall <= 1'b1;
    wr(jlc_pkg::ADDR_CFG, cfgw(1, 1, 1, 32, 1, 8), rs);
    for (int i = 0; i < 3; i++) begin
      wr(jlc_pkg::ADDR_RATE, 32'(fq[i]), rs);
      repeat (20) @(posedge aclk);
    end
    rd(jlc_pkg::ADDR_STATUS, d, rs);
    chk("busy full", 32'(d[11]), 32'h1);
    chk("res_valid held", 32'(res_valid), 32'h1);
    stall <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      get(r);
      chk("order", 32'(r.slr_x10), 32'(fq[i] * 100));
    end
    rd(jlc_pkg::ADDR_STATUS, d, rs);
    chk("busy drained", 32'(d[11]), 32'h0);
    report_and_stop();
  end
endmodule
